// ---- gmdp_board_mdl.sv ----
// Board model: pin loopback, pull-ups, external drivers and debug probe
module gmdp_board_mdl (
  input  wire logic        clk,
  input  wire logic [44:0] pin_out,
  input  wire logic [44:0] pin_oe,
  input  wire logic [44:0] pin_pullup_dis,
  input  wire logic [44:0] ext_val,
  input  wire logic [44:0] ext_en,
  output logic      [44:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wobble_q = 1'b0;

  // Floating pins wander so a stale value never passes
  always @(posedge clk) wobble_q <= !wobble_q;

  always_comb begin
    for (int i = 0; i < 45; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      // Probe clock only while a session runs; board clock moved away then
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (!pin_pullup_dis[i]) pin_in[i] = 1'b1;
      else pin_in[i] = wobble_q ^ i[0];
    end
  end
endmodule : gmdp_board_mdl

// ---- gmdp_cfg.svh ----
// Register offsets, write masks, reset values, pin positions and qualifier select codes for the pin mux block
`ifndef GMDP_CFG_SVH
`define GMDP_CFG_SVH

// ----------------------------------------------------------------------------
// Offsets in 16-bit word addresses
// ----------------------------------------------------------------------------
`define GMDP_PA_CTRL     16'h6f80
`define GMDP_PA_QSEL_LO  16'h6f82
`define GMDP_PA_QSEL_HI  16'h6f84
`define GMDP_PA_MUX_LO   16'h6f86
`define GMDP_PA_MUX_HI   16'h6f88
`define GMDP_PA_DIR      16'h6f8a
`define GMDP_PA_PUD      16'h6f8c
`define GMDP_PB_CTRL     16'h6f90
`define GMDP_PB_QSEL     16'h6f92
`define GMDP_PB_MUX      16'h6f96
`define GMDP_PB_DIR      16'h6f9a
`define GMDP_PB_PUD      16'h6f9c
`define GMDP_AIO_MUX     16'h6fb6
`define GMDP_AIO_DIR     16'h6fba
`define GMDP_PA_DAT      16'h6fc0
`define GMDP_PA_SET      16'h6fc2
`define GMDP_PA_CLR      16'h6fc4
`define GMDP_PA_INV      16'h6fc6
`define GMDP_PB_DAT      16'h6fc8
`define GMDP_PB_SET      16'h6fca
`define GMDP_PB_CLR      16'h6fcc
`define GMDP_PB_INV      16'h6fce
`define GMDP_AIO_DAT     16'h6fd8
`define GMDP_AIO_SET     16'h6fda
`define GMDP_AIO_CLR     16'h6fdc
`define GMDP_AIO_INV     16'h6fde
`define GMDP_XSEL12      16'h6fe0
`define GMDP_XSEL3       16'h6fe2
`define GMDP_WAKE_SEL    16'h6fe8

// ----------------------------------------------------------------------------
// Field masks and reset values
// ----------------------------------------------------------------------------
`define GMDP_MASK_ALL    32'hffffffff
`define GMDP_MASK_PB1    32'h00001fff
`define GMDP_MASK_PB2    32'h03ffffff
`define GMDP_MASK_AIO1   32'h0000ffff
`define GMDP_MASK_XSEL   32'h001f001f
`define GMDP_RST_REG     32'h00000000

// ----------------------------------------------------------------------------
// Pin positions and timing
// ----------------------------------------------------------------------------
`define GMDP_PIN_TDI     35
`define GMDP_PIN_TMS     36
`define GMDP_PIN_TDO     37
`define GMDP_PIN_TCK     38
`define GMDP_QSEL_SYNC   2'h0
`define GMDP_QSEL_3SMP   2'h1
`define GMDP_QSEL_6SMP   2'h2

`endif

// ---- gmdp_gpio.sv ----
// Pin multiplexer with shared debug pins, port A/B and analog-shared lines
//
// What this block does
// (R1) Debug port five pins; four double as I/O
// (R2) Debug reset level picks debug or I/O
// (R3) Debug mode removes I/O from shared pins
// (R4) Board clocks device elsewhere during debug sessions
// (R5) Three peripheral slots plus software I/O per pin
// (R6) 45 pins: port A 0-31, B 32-44
// (R7) Registers take 32-bit and 16-bit accesses
// (R8) Port B: ctrl, qsel, mux, dir, pud
// (R9) Port A qualifier select in two registers
// (R10) Port A function select in two registers
// (R11) Per-pin direction and pull-up disable bits
// (R12) Data, set, clear, toggle per port
// (R13) Analog lines get mux, dir, data registers
// (R14) Three interrupt selects pick a port A pin
// (R15) Wake select picks port A wake pins
// (R16) Select registers write only while unlocked
// (R17) Mux/qualifier writes act two cycles later
// (R18) Reserved mux code leaves pin undefined
// (R19) Ones set, clear or invert latch bits
// (R20) Direction one drives pin from latch
`include "gmdp_cfg.svh"

module gmdp_gpio (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [15:0]  bus_addr,
  input  wire logic         bus_wr,
  input  wire logic         bus_rd,
  input  wire logic         bus_wide,
  input  wire logic [31:0]  bus_wdata,
  input  wire logic         protected_write_unlock,
  output logic      [31:0]  bus_rdata,
  input  wire logic [44:0]  pin_in,
  output logic      [44:0]  pin_out,
  output logic      [44:0]  pin_oe,
  output logic      [44:0]  pin_pullup_dis,
  input  wire logic [134:0] periph_out,
  input  wire logic [134:0] periph_oe,
  output logic      [44:0]  periph_in,
  input  wire logic [15:0]  analog_shared_io_in,
  output logic      [15:0]  analog_shared_io_out,
  output logic      [15:0]  analog_shared_io_oe,
  output logic      [15:0]  analog_shared_io_analog_en,
  output logic              external_interrupt_one,
  output logic              external_interrupt_two,
  output logic              external_interrupt_three,
  output logic              low_power_wake,
  input  wire logic         dbg_reset,
  input  wire logic         dbg_tdo,
  input  wire logic         dbg_tdo_oe,
  output logic              dbg_tck,
  output logic              dbg_tdi,
  output logic              dbg_tms
);

  gmdp_pkg::gmdp_state_t s_q;
  gmdp_pkg::gmdp_state_t s_d;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] put16(input logic [31:0] cur, input logic hi,
                                        input logic [15:0] wd, input logic [31:0] msk);
    logic [31:0] v;
    v = hi ? {wd, cur[15:0]} : {cur[31:16], wd};
    return v & msk;
  endfunction : put16

  function automatic logic [31:0] spread(input logic hi, input logic [15:0] wd);
    return hi ? {wd, 16'h0000} : {16'h0000, wd};
  endfunction : spread

  // --------------------------------------------------------------------------
  // Combinational next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [1:0]   hsel;
    logic [15:0]  pair;
    logic [15:0]  wd;
    logic [31:0]  m;
    logic [31:0]  rd32;
    logic [44:0]  dir_all;
    logic [44:0]  lat_all;
    logic [44:0]  pud_all;
    logic [7:0]   qp;
    logic [5:0]   tick;
    logic [2:0]   grp;
    logic [1:0]   code;
    logic [1:0]   qs;
    logic [5:0]   w;
    logic         dbg_mode;
    logic [44:0]  in_vis;
    s_d = s_q;
    hsel = '0;
    pair = {bus_addr[15:1], 1'b0};
    wd = '0;
    m = '0;
    rd32 = '0;
    qp = '0;
    tick = '0;
    grp = '0;
    code = '0;
    qs = '0;
    w = '0;
    dir_all = '0;
    lat_all = '0;
    pud_all = '0;
    in_vis = '0;
    dbg_mode = dbg_reset; // (R2)

    // ------------------------------------------------------------------------
    // Register writes, one halfword lane at a time
    // ------------------------------------------------------------------------
    if (bus_wr) begin
      hsel = bus_wide ? 2'b11 : (bus_addr[0] ? 2'b10 : 2'b01); // (R7)
    end
    for (int h = 0; h < 2; h++) begin
      wd = (bus_wide && h == 1) ? bus_wdata[31:16] : bus_wdata[15:0];
      m = spread(h[0], wd);
      if (hsel[h]) begin
        unique case (pair)
          `GMDP_PA_DAT:  s_d.pa_lat  = put16(s_d.pa_lat, h[0], wd, `GMDP_MASK_ALL); // (R12)
          `GMDP_PA_SET:  s_d.pa_lat  = s_d.pa_lat | m;               // (R19)
          `GMDP_PA_CLR:  s_d.pa_lat  = s_d.pa_lat & ~m;              // (R19)
          `GMDP_PA_INV:  s_d.pa_lat  = s_d.pa_lat ^ m;               // (R19)
          `GMDP_PB_DAT:  s_d.pb_lat  = put16(s_d.pb_lat, h[0], wd, `GMDP_MASK_PB1); // (R12)
          `GMDP_PB_SET:  s_d.pb_lat  = (s_d.pb_lat | m) & `GMDP_MASK_PB1;
          `GMDP_PB_CLR:  s_d.pb_lat  = s_d.pb_lat & ~m;
          `GMDP_PB_INV:  s_d.pb_lat  = (s_d.pb_lat ^ m) & `GMDP_MASK_PB1;
          `GMDP_AIO_DAT: s_d.aio_lat = put16(s_d.aio_lat, h[0], wd, `GMDP_MASK_AIO1); // (R13)
          `GMDP_AIO_SET: s_d.aio_lat = (s_d.aio_lat | m) & `GMDP_MASK_AIO1;
          `GMDP_AIO_CLR: s_d.aio_lat = s_d.aio_lat & ~m;
          `GMDP_AIO_INV: s_d.aio_lat = (s_d.aio_lat ^ m) & `GMDP_MASK_AIO1;
          default: begin
          end
        endcase
        // Configuration and select registers are write-protected
        if (protected_write_unlock) begin // (R16)
          unique case (pair)
            `GMDP_PA_CTRL:    s_d.pa_ctrl  = put16(s_d.pa_ctrl, h[0], wd, `GMDP_MASK_ALL);
            `GMDP_PA_QSEL_LO: s_d.pa_qsel[31:0] =
                                put16(s_d.pa_qsel[31:0], h[0], wd, `GMDP_MASK_ALL); // (R9)
            `GMDP_PA_QSEL_HI: s_d.pa_qsel[63:32] =
                                put16(s_d.pa_qsel[63:32], h[0], wd, `GMDP_MASK_ALL); // (R9)
            `GMDP_PA_MUX_LO:  s_d.pa_mux[31:0] =
                                put16(s_d.pa_mux[31:0], h[0], wd, `GMDP_MASK_ALL); // (R10)
            `GMDP_PA_MUX_HI:  s_d.pa_mux[63:32] =
                                put16(s_d.pa_mux[63:32], h[0], wd, `GMDP_MASK_ALL); // (R10)
            `GMDP_PA_DIR:     s_d.pa_dir   = put16(s_d.pa_dir, h[0], wd, `GMDP_MASK_ALL); // (R11)
            `GMDP_PA_PUD:     s_d.pa_pud   = put16(s_d.pa_pud, h[0], wd, `GMDP_MASK_ALL); // (R11)
            `GMDP_PB_CTRL:    s_d.pb_ctrl  = put16(s_d.pb_ctrl, h[0], wd, `GMDP_MASK_AIO1); // (R8)
            `GMDP_PB_QSEL:    s_d.pb_qsel  = put16(s_d.pb_qsel, h[0], wd, `GMDP_MASK_PB2); // (R8)
            `GMDP_PB_MUX:     s_d.pb_mux   = put16(s_d.pb_mux, h[0], wd, `GMDP_MASK_PB2); // (R8)
            `GMDP_PB_DIR:     s_d.pb_dir   = put16(s_d.pb_dir, h[0], wd, `GMDP_MASK_PB1); // (R8)
            `GMDP_PB_PUD:     s_d.pb_pud   = put16(s_d.pb_pud, h[0], wd, `GMDP_MASK_PB1); // (R8)
            `GMDP_AIO_MUX:    s_d.aio_mux  = put16(s_d.aio_mux, h[0], wd, `GMDP_MASK_ALL); // (R13)
            `GMDP_AIO_DIR:    s_d.aio_dir  = put16(s_d.aio_dir, h[0], wd, `GMDP_MASK_AIO1); // (R13)
            `GMDP_XSEL12:     s_d.xsel12   = put16(s_d.xsel12, h[0], wd, `GMDP_MASK_XSEL); // (R14)
            `GMDP_XSEL3:      s_d.xsel3    = put16(s_d.xsel3, h[0], wd, `GMDP_MASK_XSEL); // (R14)
            `GMDP_WAKE_SEL:   s_d.wake_sel = put16(s_d.wake_sel, h[0], wd, `GMDP_MASK_ALL); // (R15)
            default: begin
            end
          endcase
        end
      end
    end

    // ------------------------------------------------------------------------
    // Mux and qualifier settings reach the pins two clocks after the write
    // ------------------------------------------------------------------------
    s_d.sel_dly = {s_q.pb_qsel, s_q.pa_qsel, s_q.aio_mux, s_q.pb_mux, s_q.pa_mux}; // (R17)

    // ------------------------------------------------------------------------
    // Qualification sampling clock, one divider per group of up to eight pins (pins 40-44 form a group of five)
    // ------------------------------------------------------------------------
    for (int g = 0; g < 6; g++) begin
      qp = (g < 4) ? s_q.pa_ctrl[8*g +: 8] : s_q.pb_ctrl[8*(g-4) +: 8];
      tick[g] = (s_q.cnt[9*g +: 9] == 9'h000);
      // Period of zero samples every clock; otherwise twice the setting
      if (tick[g]) begin
        s_d.cnt[9*g +: 9] = (qp == 8'h00) ? 9'h000 : 9'({qp, 1'b0} - 9'h001);
      end else begin
        s_d.cnt[9*g +: 9] = s_q.cnt[9*g +: 9] - 9'h001;
      end
    end

    // ------------------------------------------------------------------------
    // Per-pin input qualification and output drive
    // ------------------------------------------------------------------------
    dir_all = {s_q.pb_dir[12:0], s_q.pa_dir};
    lat_all = {s_q.pb_lat[12:0], s_q.pa_lat};
    pud_all = {s_q.pb_pud[12:0], s_q.pa_pud};
    for (int p = 0; p < 45; p++) begin // (R6)
      grp = (p < 32) ? 3'(p / 8) : 3'(4 + (p - 32) / 8);
      code = s_q.sel_dly[2*p +: 2];
      qs = s_q.sel_dly[128 + 2*p +: 2];
      if (tick[grp]) begin
        s_d.smp[6*p +: 6] = {s_q.smp[6*p +: 5], pin_in[p]};
      end
      w = s_q.smp[6*p +: 6];
      unique case (qs)
        `GMDP_QSEL_SYNC: s_d.qual[p] = w[0];
        `GMDP_QSEL_3SMP: begin
          if (w[2:0] == 3'h7 || w[2:0] == 3'h0) begin
            s_d.qual[p] = w[0];
          end
        end
        `GMDP_QSEL_6SMP: begin
          if (w == 6'h3f || w == 6'h00) begin
            s_d.qual[p] = w[0];
          end
        end
        default: s_d.qual[p] = pin_in[p];
      endcase
      // Code zero is software I/O; others hand the pin to a peripheral slot.
      // Reserved slots are whatever the peripheral fabric ties there.
      if (code == 2'h0) begin
        s_d.pin_out[p] = lat_all[p];                               // (R20)
        s_d.pin_oe[p] = dir_all[p];                                // (R20)
      end else begin
        s_d.pin_out[p] = periph_out[3*p + int'(code) - 1];         // (R5) (R18)
        s_d.pin_oe[p] = periph_oe[3*p + int'(code) - 1];           // (R5) (R18)
      end
    end
    s_d.pud = pud_all; // (R11)
    in_vis = s_q.qual;

    // ------------------------------------------------------------------------
    // Shared debug pins
    // ------------------------------------------------------------------------
    if (dbg_mode) begin // (R3)
      s_d.pin_oe[`GMDP_PIN_TDI] = 1'b0;
      s_d.pin_oe[`GMDP_PIN_TMS] = 1'b0;
      s_d.pin_oe[`GMDP_PIN_TCK] = 1'b0;
      s_d.pin_out[`GMDP_PIN_TDO] = dbg_tdo;       // (R1)
      s_d.pin_oe[`GMDP_PIN_TDO] = dbg_tdo_oe;     // (R1)
      in_vis[`GMDP_PIN_TCK:`GMDP_PIN_TDI] = 4'h0; // (R3)
    end
    s_d.dbg = dbg_mode ? {pin_in[`GMDP_PIN_TCK], pin_in[`GMDP_PIN_TDI], pin_in[`GMDP_PIN_TMS]}
                       : 3'h0; // (R1)
    s_d.periph_in = in_vis;

    // ------------------------------------------------------------------------
    // Analog-shared lines: code zero is digital I/O, anything else analog
    // ------------------------------------------------------------------------
    s_d.aio_smp = analog_shared_io_in;
    for (int i = 0; i < 16; i++) begin
      s_d.aio_analog[i] = (s_q.sel_dly[96 + 2*i +: 2] != 2'h0); // (R13)
      s_d.aio_out[i] = s_q.aio_lat[i];
      s_d.aio_oe[i] = s_q.aio_dir[i] && !s_d.aio_analog[i];
    end

    // ------------------------------------------------------------------------
    // Interrupt and wake source selection from port A
    // ------------------------------------------------------------------------
    s_d.xint[0] = in_vis[s_q.xsel12[4:0]];  // (R14)
    s_d.xint[1] = in_vis[s_q.xsel12[20:16]]; // (R14)
    s_d.xint[2] = in_vis[s_q.xsel3[4:0]];   // (R14)
    s_d.wake = |(in_vis[31:0] & s_q.wake_sel); // (R15)

    // ------------------------------------------------------------------------
    // Register reads; write-only and unmapped words read as zero
    // ------------------------------------------------------------------------
    unique case (pair)
      `GMDP_PA_CTRL:    rd32 = s_q.pa_ctrl;
      `GMDP_PA_QSEL_LO: rd32 = s_q.pa_qsel[31:0];
      `GMDP_PA_QSEL_HI: rd32 = s_q.pa_qsel[63:32];
      `GMDP_PA_MUX_LO:  rd32 = s_q.pa_mux[31:0];
      `GMDP_PA_MUX_HI:  rd32 = s_q.pa_mux[63:32];
      `GMDP_PA_DIR:     rd32 = s_q.pa_dir;
      `GMDP_PA_PUD:     rd32 = s_q.pa_pud;
      `GMDP_PB_CTRL:    rd32 = s_q.pb_ctrl;
      `GMDP_PB_QSEL:    rd32 = s_q.pb_qsel;
      `GMDP_PB_MUX:     rd32 = s_q.pb_mux;
      `GMDP_PB_DIR:     rd32 = s_q.pb_dir;
      `GMDP_PB_PUD:     rd32 = s_q.pb_pud;
      `GMDP_AIO_MUX:    rd32 = s_q.aio_mux;
      `GMDP_AIO_DIR:    rd32 = s_q.aio_dir;
      // Port A/B data reads return the qualified pin level, not the latch; analog-shared data returns the sampled input
      `GMDP_PA_DAT:     rd32 = in_vis[31:0];
      `GMDP_PB_DAT:     rd32 = {19'h00000, in_vis[44:32]};
      `GMDP_AIO_DAT:    rd32 = {16'h0000, s_q.aio_smp};
      `GMDP_XSEL12:     rd32 = s_q.xsel12;
      `GMDP_XSEL3:      rd32 = s_q.xsel3;
      `GMDP_WAKE_SEL:   rd32 = s_q.wake_sel;
      default:          rd32 = 32'h00000000;
    endcase
    if (bus_rd) begin
      if (bus_wide) begin
        s_d.rdata = rd32; // (R7)
      end else begin
        s_d.rdata = {16'h0000, bus_addr[0] ? rd32[31:16] : rd32[15:0]}; // (R7)
      end
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from the state register
  // --------------------------------------------------------------------------
  assign bus_rdata                  = s_q.rdata;
  assign pin_out                    = s_q.pin_out;
  assign pin_oe                     = s_q.pin_oe;
  assign pin_pullup_dis             = s_q.pud;
  assign periph_in                  = s_q.periph_in;
  assign analog_shared_io_out       = s_q.aio_out;
  assign analog_shared_io_oe        = s_q.aio_oe;
  assign analog_shared_io_analog_en = s_q.aio_analog;
  assign external_interrupt_one     = s_q.xint[0];
  assign external_interrupt_two     = s_q.xint[1];
  assign external_interrupt_three   = s_q.xint[2];
  assign low_power_wake             = s_q.wake;
  assign dbg_tms                    = s_q.dbg[0];
  assign dbg_tdi                    = s_q.dbg[1];
  assign dbg_tck                    = s_q.dbg[2];

endmodule : gmdp_gpio

// ---- gmdp_gpio_chk.sv ----
// Port-level assertions for the pin mux block
module gmdp_gpio_chk (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic [44:0] pin_in,
  input wire logic [44:0] pin_out,
  input wire logic [44:0] pin_oe,
  input wire logic        dbg_reset,
  input wire logic        dbg_tdo,
  input wire logic        dbg_tdo_oe,
  input wire logic        dbg_tck,
  input wire logic        dbg_tdi,
  input wire logic        dbg_tms
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  chk_dbg_no_gpio: assert property (
    dbg_reset [*2] |-> !pin_oe[35] && !pin_oe[36] && !pin_oe[38])
    else $error("Shared pin driven in debug mode");
  chk_dbg_in_path: assert property (
    $past(dbg_reset) |-> dbg_tck == $past(pin_in[38]) && dbg_tdi == $past(pin_in[35])
      && dbg_tms == $past(pin_in[36]))
    else $error("Debug input does not follow its pin");
  chk_gpio_dbg_low: assert property (
    !$past(dbg_reset) |-> {dbg_tck, dbg_tdi, dbg_tms} == 3'h0)
    else $error("Debug inputs active in pin mode");
  chk_tdo_drive: assert property (
    $past(dbg_reset) |-> pin_out[37] == $past(dbg_tdo) && pin_oe[37] == $past(dbg_tdo_oe))
    else $error("Debug data-out not on its pin");
  chk_set_bit: assert property (
    bus_wr && bus_addr == 16'h6fc2 && bus_wdata[0] |-> ##2 pin_out[0])
    else $error("Set write did not raise the latch");
  chk_clr_bit: assert property (
    bus_wr && bus_addr == 16'h6fc4 && bus_wdata[0] |-> ##2 !pin_out[0])
    else $error("Clear write did not drop the latch");
  chk_rd_hold: assert property (
    !bus_rd |=> $stable(bus_rdata))
    else $error("Read data moved without a read");
  chk_set_rd_zero: assert property (
    bus_rd && bus_addr == 16'h6fc2 |=> bus_rdata == 32'h0)
    else $error("Set register read not zero");
endmodule : gmdp_gpio_chk

bind gmdp_gpio gmdp_gpio_chk u_gmdp_gpio_chk (.*);

// ---- gmdp_pkg.sv ----
// Types shared by the pin mux block
package gmdp_pkg;

  typedef struct packed {
    logic [31:0]  pa_ctrl;
    logic [63:0]  pa_qsel;
    logic [63:0]  pa_mux;
    logic [31:0]  pa_dir;
    logic [31:0]  pa_pud;
    logic [31:0]  pb_ctrl;
    logic [31:0]  pb_qsel;
    logic [31:0]  pb_mux;
    logic [31:0]  pb_dir;
    logic [31:0]  pb_pud;
    logic [31:0]  aio_mux;
    logic [31:0]  aio_dir;
    logic [31:0]  xsel12;
    logic [31:0]  xsel3;
    logic [31:0]  wake_sel;
    logic [31:0]  pa_lat;
    logic [31:0]  pb_lat;
    logic [31:0]  aio_lat;
    logic [223:0] sel_dly;
    logic [53:0]  cnt;
    logic [269:0] smp;
    logic [44:0]  qual;
    logic [15:0]  aio_smp;
    logic [44:0]  pin_out;
    logic [44:0]  pin_oe;
    logic [44:0]  pud;
    logic [44:0]  periph_in;
    logic [15:0]  aio_out;
    logic [15:0]  aio_oe;
    logic [15:0]  aio_analog;
    logic [2:0]   xint;
    logic         wake;
    logic [31:0]  rdata;
    logic [2:0]   dbg;
  } gmdp_state_t;

endpackage : gmdp_pkg

// ---- gmdp_tb.sv ----
// Self-checking bench for the pin mux block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0, arst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, bus_wide = 1'b1;
  logic [15:0]  bus_addr = 16'h0;
  logic [31:0]  bus_wdata = 32'h0, bus_rdata;
  logic         protected_write_unlock = 1'b0;
  logic [44:0]  pin_in, pin_out, pin_oe, pin_pullup_dis, periph_in;
  logic [44:0]  ext_val = 45'h0, ext_en = 45'h0;
  logic [134:0] periph_out = 135'h0, periph_oe = 135'h0;
  logic [15:0]  analog_shared_io_in = 16'h0, analog_shared_io_out;
  logic [15:0]  analog_shared_io_oe, analog_shared_io_analog_en;
  logic         external_interrupt_one, external_interrupt_two, external_interrupt_three;
  logic         low_power_wake, dbg_tck, dbg_tdi, dbg_tms;
  logic         dbg_reset = 1'b0, dbg_tdo = 1'b0, dbg_tdo_oe = 1'b0;
  int           failures = 0, n_tests = 0;

  gmdp_gpio u_gmdp_gpio (.*);
  gmdp_board_mdl u_gmdp_board_mdl (.*);

  initial begin
    forever #2.5 clk = !clk;
  end

  task automatic end_sim();
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [15:0] a, logic [31:0] d, logic w = 1'b1);
    @(negedge clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wide = w;
    bus_wr = 1'b1;
    @(posedge clk);
    @(negedge clk);
    bus_wr = 1'b0;
  endtask : wr

  task automatic rdc(string n, logic [15:0] a, logic [31:0] e);
    @(negedge clk);
    bus_addr = a;
    bus_wide = 1'b1;
    bus_rd = 1'b1;
    @(posedge clk);
    @(negedge clk);
    bus_rd = 1'b0;
    chk(n, bus_rdata, e);
  endtask : rdc

  // Covers pin sample, qualify and register stages
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask : settle

  task automatic s_regs();
    rdc("pa_dir_rst", 16'h6f8a, 32'h0);
    wr(16'h6f8a, 32'hffffffff);
    rdc("pa_dir_locked", 16'h6f8a, 32'h0);
    wr(16'h6fe0, 32'hffffffff);
    rdc("irq_sel_locked", 16'h6fe0, 32'h0);
    protected_write_unlock = 1'b1;
    wr(16'h6fe0, 32'hffffffff);
    rdc("irq_sel", 16'h6fe0, 32'h001f001f);
    wr(16'h6f9a, 32'hffffffff);
    rdc("pb_dir", 16'h6f9a, 32'h00001fff);
    wr(16'h6f9a, 32'h0);
    wr(16'h6f9a, 32'h00000008, 1'b0);
    rdc("pb_dir_half", 16'h6f9a, 32'h00000008);
    wr(16'h6f85, 32'h0000abcd, 1'b0);
    rdc("pa_qual_hi", 16'h6f84, 32'habcd0000);
    wr(16'h6f8e, 32'hffffffff);
    rdc("unmapped", 16'h6f8e, 32'h0);
    rdc("set_read", 16'h6fc2, 32'h0);
  endtask : s_regs

  task automatic s_dio();
    logic [15:0] ops [4] = '{16'h6fc2, 16'h6fc6, 16'h6fc6, 16'h6fc4};
    logic [31:0] exp [4] = '{32'hffffffff, 32'hfffffffe, 32'hffffffff, 32'hfffffffe};
    wr(16'h6f8a, 32'h00000001);
    for (int k = 0; k < 4; k++) begin
      wr(ops[k], 32'h1);
      settle();
      rdc("pa_dat", 16'h6fc0, exp[k]);
    end
    chk("pin0_oe", pin_oe[0], 1'b1);
  endtask : s_dio

  task automatic s_mux();
    periph_oe[5:3] = 3'h7;
    periph_out[5:3] = 3'h5;
    for (int k = 1; k < 4; k++) begin
      wr(16'h6f86, 32'(k) << 2);
      @(posedge clk);
      #1 chk("mux_early", pin_out[1], k == 1 ? 1'b0 : periph_out[1+k]);
      @(posedge clk);
      #1 chk("mux_slot", pin_out[1], periph_out[2+k]);
      chk("mux_oe", pin_oe[1], 1'b1);
    end
    wr(16'h6f86, 32'h0);
  endtask : s_mux

  task automatic s_dbg();
    wr(16'h6fca, 32'h00000008);
    settle();
    chk("gpio35_oe", pin_oe[35], 1'b1);
    ext_en[38] = 1'b1;
    ext_val[38] = 1'b1;
    dbg_tdo = 1'b1;
    dbg_tdo_oe = 1'b1;
    dbg_reset = 1'b1;
    settle();
    chk("dbg35_oe", pin_oe[35], 1'b0);
    chk("dbg35_in", periph_in[35], 1'b0);
    chk("dbg_clk", dbg_tck, 1'b1);
    chk("dbg_out", {pin_oe[37], pin_out[37]}, 2'h3);
    dbg_reset = 1'b0;
    ext_en[38] = 1'b0;
    settle();
    chk("back35_oe", pin_oe[35], 1'b1);
    chk("back_clk", dbg_tck, 1'b0);
  endtask : s_dbg

  task automatic s_irq();
    int i;
    wr(16'h6fe0, 32'h00050005);
    wr(16'h6fe2, 32'h00000005);
    wr(16'h6fe8, 32'h00000020);
    ext_en[5] = 1'b1;
    settle();
    chk("irq_lo", {external_interrupt_one, external_interrupt_two,
                   external_interrupt_three, low_power_wake}, 4'h0);
    ext_val[5] = 1'b1;
    for (i = 0; i < 20 && external_interrupt_one !== 1'b1; i++) @(negedge clk);
    if (i == 20) begin
      failures++;
      end_sim();
    end
    settle();
    chk("irq_hi", {external_interrupt_one, external_interrupt_two,
                   external_interrupt_three, low_power_wake}, 4'hf);
    wr(16'h6fe8, 32'h0);
    settle();
    chk("wake_masked", low_power_wake, 1'b0);
  endtask : s_irq

  task automatic s_analog();
    wr(16'h6fba, 32'h1);
    wr(16'h6fda, 32'h1);
    settle();
    chk("an_drive", {analog_shared_io_oe[0], analog_shared_io_out[0]}, 2'h3);
    wr(16'h6fb6, 32'h3);
    settle();
    chk("an_sel", {analog_shared_io_analog_en[0], analog_shared_io_oe[0]}, 2'h2);
    // Last scenario: disable the pull-up on pin 1 only and check the pull-up disable outputs
    wr(16'h6f8c, 32'h00000002);
    settle();
    chk("pud_pin1", pin_pullup_dis[1:0], 2'h2);
  endtask : s_analog

  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    s_regs();
    s_dio();
    s_mux();
    s_dbg();
    s_irq();
    s_analog();
    end_sim();
  end
endmodule : tb
